// ==== core/cpb_pkg.sv ====
// Overview of operation
// - Every stage takes exactly one pipeline cycle.
// - A new instruction enters fetch in step with the pipeline clock.
// - When a stage empties, the next instruction advances into it.
// - A data miss holds every stage, from fetch through writeback.
// - Scalar variant uses five stages wide, six stages compact.
// - Stage order fetch to writeback; translate exists only in compact mode.
// - Superscalar variant carries two instructions per stage, two per cycle.
// - Superscalar adds data read stage: six stages wide, seven compact.
// - Two-phase variant has five stages, each split into two phases.
// - Taken branches and all jumps create branch delay, except in two-phase compact mode.
// - The instruction right after a jump or branch is the delay slot.
// - Scalar variant resolves the target in execute for fetch.
// - Scalar delay is two cycles wide, three cycles compact.
// - Slot executes in wide mode unless likely; compact mode drops it.
// - Superscalar resolves the target in register read for fetch.
// - Superscalar slot choice depends on branch address versus its partner.
// - Superscalar wide mode: two delay cycles, slot runs unless likely.
// - Superscalar compact mode: three delay cycles, slot dropped.
// - Two-phase variant resolves the target in register read.
// - Two-phase wide mode: one delay cycle, slot runs unless likely.
// - Two-phase compact mode: no delay cycle, slot dropped.
package cpb_pkg;

    typedef enum logic [2:0] {
        CPB_SCALAR = 3'h1,
        CPB_SUPER  = 3'h2,
        CPB_TWOPH  = 3'h4
    } cpb_variant_t;

    localparam int CPB_WORD_W = 32;
    localparam int CPB_STAGES = 7;

    localparam int CPB_FETCH_STAGE             = 0;
    localparam int CPB_TRANSLATE_STAGE         = 1;
    localparam int CPB_REGISTER_READ_STAGE     = 2;
    localparam int CPB_EXECUTE_STAGE           = 3;
    localparam int CPB_DATA_CACHE_FETCH_STAGE  = 4;
    localparam int CPB_DATA_READ_STAGE         = 5;
    localparam int CPB_WRITEBACK_STAGE         = 6;

    localparam logic [1:0] CPB_DLY_SCALAR_WIDE    = 2'h2;
    localparam logic [1:0] CPB_DLY_SCALAR_COMPACT = 2'h3;
    localparam logic [1:0] CPB_DLY_SUPER_WIDE     = 2'h2;
    localparam logic [1:0] CPB_DLY_SUPER_COMPACT  = 2'h3;
    localparam logic [1:0] CPB_DLY_TWOPH_WIDE     = 2'h1;
    localparam logic [1:0] CPB_DLY_TWOPH_COMPACT  = 2'h0;

    function automatic logic stage_present(cpb_variant_t v,
                                           logic compact, int s);
        if (s == CPB_TRANSLATE_STAGE)
            return compact && (v != CPB_TWOPH);
        if (s == CPB_DATA_READ_STAGE)
            return v == CPB_SUPER;
        return 1'h1;
    endfunction : stage_present

    // Nearest present stage behind s in program flow
    function automatic int prev_stage(cpb_variant_t v,
                                      logic compact, int s);
        if (s == CPB_REGISTER_READ_STAGE &&
            !stage_present(v, compact, CPB_TRANSLATE_STAGE))
            return CPB_FETCH_STAGE;
        if (s == CPB_WRITEBACK_STAGE && v != CPB_SUPER)
            return CPB_DATA_CACHE_FETCH_STAGE;
        return s - 1;
    endfunction : prev_stage

    function automatic int resolve_stage(cpb_variant_t v);
        return (v == CPB_SCALAR) ? CPB_EXECUTE_STAGE
                                 : CPB_REGISTER_READ_STAGE;
    endfunction : resolve_stage

    function automatic logic [1:0] branch_delay(cpb_variant_t v,
                                                logic compact);
        unique case (v)
            CPB_SCALAR: return compact ? CPB_DLY_SCALAR_COMPACT
                                       : CPB_DLY_SCALAR_WIDE;
            CPB_SUPER:  return compact ? CPB_DLY_SUPER_COMPACT
                                       : CPB_DLY_SUPER_WIDE;
            CPB_TWOPH:  return compact ? CPB_DLY_TWOPH_COMPACT
                                       : CPB_DLY_TWOPH_WIDE;
            default:    return 2'h0;
        endcase
    endfunction : branch_delay

endpackage : cpb_pkg

// ==== core/cpb_delay_ctl.sv ====
`timescale 1ns/1ns
`default_nettype none
module cpb_delay_ctl (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic       step,
    input  wire logic       start,
    input  wire logic [1:0] cycles,
    output logic            hold
);

    typedef enum logic [1:0] {
        CPB_IDLE = 2'h1,
        CPB_HOLD = 2'h2
    } cpb_dstate_t;

    cpb_dstate_t state;
    logic [1:0]  count;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= CPB_IDLE;
            count <= 2'h0;
        end else if (clk_en) begin
            unique case (state)
                CPB_IDLE: begin
                    if (start && cycles != 2'h0) begin
                        state <= CPB_HOLD;
                        count <= cycles;
                    end
                end
                CPB_HOLD: begin
                    // Counts pipeline cycles, not clocks, so it stretches
                    // with phases and stalls
                    if (step) begin
                        count <= count - 2'h1;
                        if (count == 2'h1)
                            state <= CPB_IDLE;
                    end
                end
                default: begin
                    state <= CPB_IDLE;
                    count <= 2'h0;
                end
            endcase
        end
    end

    assign hold = (state == CPB_HOLD);

endmodule : cpb_delay_ctl
`default_nettype wire

// ==== core/cpb_pipe.sv ====
`timescale 1ns/1ns
`default_nettype none
module cpb_pipe #(
    parameter cpb_pkg::cpb_variant_t VARIANT = cpb_pkg::CPB_SCALAR
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        compact_mode,
    input  wire logic [1:0]  fetch_valid,
    input  wire logic [31:0] fetch_pc0,
    input  wire logic [31:0] fetch_pc1,
    input  wire logic [31:0] fetch_instr0,
    input  wire logic [31:0] fetch_instr1,
    input  wire logic [1:0]  fetch_is_jump,
    input  wire logic [1:0]  fetch_is_branch,
    input  wire logic [1:0]  fetch_is_likely,
    input  wire logic [1:0]  branch_taken,
    input  wire logic [31:0] target_pc0,
    input  wire logic [31:0] target_pc1,
    input  wire logic        data_wait,
    output logic             fetch_ready,
    output logic             redirect_valid,
    output logic [31:0]      redirect_pc,
    output logic             slot_dropped,
    output logic             phase_second,
    output logic             pipe_stall,
    output logic [6:0]       stage_valid0,
    output logic [6:0]       stage_valid1,
    output logic [1:0]       retire_valid,
    output logic [31:0]      retire_pc0,
    output logic [31:0]      retire_pc1,
    output logic [31:0]      retire_instr0,
    output logic [31:0]      retire_instr1
);

    localparam int NS  = cpb_pkg::CPB_STAGES;
    localparam int W   = cpb_pkg::CPB_WORD_W;
    localparam int LN  = (VARIANT == cpb_pkg::CPB_SUPER) ? 2 : 1;
    localparam int RES = cpb_pkg::resolve_stage(VARIANT);
    localparam int DCF = cpb_pkg::CPB_DATA_CACHE_FETCH_STAGE;
    localparam int TRS = cpb_pkg::CPB_TRANSLATE_STAGE;
    localparam int WBS = cpb_pkg::CPB_WRITEBACK_STAGE;
    localparam int DRS = cpb_pkg::CPB_DATA_READ_STAGE;

    logic         vld   [2][NS];
    logic [W-1:0] pc    [2][NS];
    logic [W-1:0] ins   [2][NS];
    logic         jmp   [2][NS];
    logic         brn   [2][NS];
    logic         lkl   [2][NS];
    logic         kill  [2][NS];

    logic         adv;
    logic         hold;
    logic [1:0]   hit;
    logic         redir_cond;
    logic         redir_now;
    logic         sel;
    logic         lo_res;
    logic         lo_prev;
    logic         br_high;
    logic         keep;
    int           rp;
    logic [1:0]   dly;
    logic [W-1:0] next_target;

    // Two-phase variant: a pipeline cycle is two clocks
    always_ff @(posedge clock) begin
        if (!rst_n)
            phase_second <= 1'h0;
        else if (clk_en)
            phase_second <= (VARIANT == cpb_pkg::CPB_TWOPH) ?
                            !phase_second : 1'h0;
    end

    // A miss only matters when a real instruction waits on it
    assign pipe_stall = data_wait && (vld[0][DCF] || vld[1][DCF]);

    assign adv = clk_en && !pipe_stall &&
                 (VARIANT != cpb_pkg::CPB_TWOPH || phase_second);

    assign dly = cpb_pkg::branch_delay(VARIANT, compact_mode);

    // Branch resolution at the variant's resolve stage
    always_comb begin
        for (int l = 0; l < 2; l++)
            hit[l] = (l < LN) && vld[l][RES] &&
                     (jmp[l][RES] ||
                      (brn[l][RES] && branch_taken[l]));
        lo_res = (LN == 2) && vld[1][RES] &&
                 (!vld[0][RES] || pc[1][RES] < pc[0][RES]);
        sel = hit[lo_res] ? lo_res : !lo_res;
        // Lower-address branch: partner at same stage is the slot
        br_high = !((LN == 2) && vld[!sel][RES] &&
                    sel == lo_res);
        rp = cpb_pkg::prev_stage(VARIANT, compact_mode, RES);
        lo_prev = (LN == 2) && vld[1][rp] &&
                  (!vld[0][rp] || pc[1][rp] < pc[0][rp]);
        keep = !compact_mode && !lkl[sel][RES];
        next_target = sel ? target_pc1 : target_pc0;
    end

    assign redir_cond = |hit;
    assign redir_now  = redir_cond && adv;

    // Younger work behind the branch is squashed except a kept slot
    always_comb begin
        for (int l = 0; l < 2; l++)
            for (int s = 0; s < NS; s++)
                kill[l][s] = 1'h0;
        if (redir_now) begin
            for (int l = 0; l < 2; l++)
                for (int s = 0; s < RES; s++)
                    kill[l][s] = 1'h1;
            if (br_high)
                kill[lo_prev][rp] = !keep;
            else
                kill[!sel][RES] = !keep;
        end
    end

    // The current fetch is refused while redirecting or in delay
    assign fetch_ready = adv && !hold && !redir_cond;

    cpb_delay_ctl u_delay (
        .clock  (clock),
        .rst_n  (rst_n),
        .clk_en (clk_en),
        .step   (adv),
        .start  (redir_now),
        .cycles (dly),
        .hold   (hold)
    );

    // Valid bits: one stage per pipeline cycle, absent stages stay empty
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            for (int l = 0; l < 2; l++)
                for (int s = 0; s < NS; s++)
                    vld[l][s] <= 1'h0;
        end else if (adv) begin
            for (int l = 0; l < 2; l++) begin
                vld[l][0] <= (l < LN) && fetch_ready &&
                             fetch_valid[l];
                for (int s = 1; s < NS; s++) begin
                    if ((l < LN) && cpb_pkg::stage_present(
                            VARIANT, compact_mode, s))
                        vld[l][s] <=
                            vld[l][cpb_pkg::prev_stage(
                                VARIANT, compact_mode, s)] &&
                            !kill[l][cpb_pkg::prev_stage(
                                VARIANT, compact_mode, s)];
                    else
                        vld[l][s] <= 1'h0;
                end
            end
        end
    end

    // Payload needs no reset; valid bits qualify it
    always_ff @(posedge clock) begin
        if (adv) begin
            pc[0][0]  <= fetch_pc0;
            pc[1][0]  <= fetch_pc1;
            ins[0][0] <= fetch_instr0;
            ins[1][0] <= fetch_instr1;
            for (int l = 0; l < 2; l++) begin
                jmp[l][0] <= fetch_is_jump[l];
                brn[l][0] <= fetch_is_branch[l];
                lkl[l][0] <= fetch_is_likely[l];
                for (int s = 1; s < NS; s++) begin
                    pc[l][s]  <= pc[l][cpb_pkg::prev_stage(
                                     VARIANT, compact_mode, s)];
                    ins[l][s] <= ins[l][cpb_pkg::prev_stage(
                                     VARIANT, compact_mode, s)];
                    jmp[l][s] <= jmp[l][cpb_pkg::prev_stage(
                                     VARIANT, compact_mode, s)];
                    brn[l][s] <= brn[l][cpb_pkg::prev_stage(
                                     VARIANT, compact_mode, s)];
                    lkl[l][s] <= lkl[l][cpb_pkg::prev_stage(
                                     VARIANT, compact_mode, s)];
                end
            end
        end
    end

    // Redirect towards fetch, one clock after resolution
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            redirect_valid <= 1'h0;
            redirect_pc    <= 32'h0000_0000;
            slot_dropped   <= 1'h0;
        end else if (clk_en) begin
            redirect_valid <= redir_now;
            slot_dropped   <= redir_now && !keep;
            if (redir_now)
                redirect_pc <= next_target;
        end
    end

    always_comb begin
        for (int s = 0; s < NS; s++) begin
            stage_valid0[s] = vld[0][s];
            stage_valid1[s] = vld[1][s];
        end
    end

    assign retire_valid  = {vld[1][WBS], vld[0][WBS]};
    assign retire_pc0    = pc[0][WBS];
    assign retire_pc1    = pc[1][WBS];
    assign retire_instr0 = ins[0][WBS];
    assign retire_instr1 = ins[1][WBS];

    // Delay actually served, in pipeline cycles, against the policy
    logic [2:0]   hold_len;
    logic [1:0]   dly_taken;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hold_len  <= 3'h0;
            dly_taken <= 2'h0;
        end else if (clk_en) begin
            if (redir_now) begin
                hold_len  <= 3'h0;
                dly_taken <= dly;
            end else if (hold && adv) begin
                hold_len <= hold_len + 3'h1;
            end
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_redirect;
        redir_now;
    endsequence

    sequence s_hold_delay;
        redir_now && dly != 2'h0;
    endsequence

    sequence s_enter_fetch;
        fetch_ready && fetch_valid[0];
    endsequence

    sequence s_keep_slot;
        redir_now && keep && br_high && !lo_prev && vld[0][rp];
    endsequence

    sequence s_drop_slot;
        redir_now && !keep && br_high && !lo_prev && vld[0][rp];
    endsequence

    a_fetch_enter:
    assert property (s_enter_fetch |=>
        vld[0][0] && pc[0][0] == $past(fetch_pc0))
        else $error("accepted fetch missing from first stage");

    a_stage_step:
    assert property ((adv && vld[0][RES] && !kill[0][RES]) |=>
        vld[0][RES+1] && pc[0][RES+1] == $past(pc[0][RES]))
        else $error("instruction did not advance one stage");

    a_miss_hold:
    assert property ((pipe_stall && clk_en) |=>
        vld[0][DCF] == $past(vld[0][DCF]) &&
        $stable(pc[0][DCF]))
        else $error("data cache stage moved during a miss");

    a_translate_gate:
    assert property ((adv && !cpb_pkg::stage_present(
        VARIANT, compact_mode, TRS)) |=> !vld[0][TRS])
        else $error("translate stage filled outside compact mode");

    a_pair_issue:
    assert property ((VARIANT == cpb_pkg::CPB_SUPER &&
        fetch_ready && fetch_valid == 2'h3) |=>
        stage_valid0[0] && stage_valid1[0])
        else $error("paired fetch not issued together");

    a_single_lane:
    assert property (VARIANT != cpb_pkg::CPB_SUPER |->
        stage_valid1 == 7'h00)
        else $error("second lane used in a scalar variant");

    a_phase_step:
    assert property ((VARIANT == cpb_pkg::CPB_TWOPH && clk_en) |=>
        phase_second != $past(phase_second))
        else $error("phase did not alternate");

    a_redirect_out:
    assert property (s_redirect |=>
        redirect_valid && redirect_pc == $past(next_target))
        else $error("redirect target not presented");

    a_slot_drop:
    assert property ((s_redirect and compact_mode) |=> slot_dropped)
        else $error("compact mode delay slot not dropped");

    a_delay_hold:
    assert property (s_hold_delay |=> !fetch_ready [*2])
        else $error("fetch not held after taken branch");

    a_no_delay:
    assert property ((s_redirect and dly == 2'h0) |=> !hold)
        else $error("delay inserted where none is due");

    a_delay_len:
    assert property ($fell(hold) |-> hold_len == {1'b0, dly_taken})
        else $error("branch delay length differs from policy");

    a_fetch_refuse:
    assert property ((adv && !fetch_ready) |=> !vld[0][0])
        else $error("refused fetch entered first stage");

    a_slot_kept:
    assert property (s_keep_slot |=> vld[0][RES])
        else $error("kept delay slot lost");

    a_slot_killed:
    assert property (s_drop_slot |=> !vld[0][RES])
        else $error("dropped delay slot still advanced");

    a_younger_squash:
    assert property (s_redirect |=> !vld[0][rp])
        else $error("work behind the delay slot survived");

    a_redirect_pulse:
    assert property ((redirect_valid && clk_en) |=> !redirect_valid)
        else $error("redirect held longer than one clock");

    a_phase_idle:
    assert property ((VARIANT == cpb_pkg::CPB_TWOPH && !phase_second)
        |=> $stable(stage_valid0))
        else $error("stages moved in the first phase");

    a_no_read_stage:
    assert property (VARIANT != cpb_pkg::CPB_SUPER |-> !vld[0][DRS])
        else $error("data read stage used outside superscalar");

endmodule : cpb_pipe
`default_nettype wire

// ==== dv/cpb_fetch_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Instruction cache stand-in: one word per cycle from a running address,
// follows redirects, flags one jump and one branch address.
module cpb_fetch_model (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        en,
    input  wire logic        load,
    input  wire logic [31:0] load_pc,
    input  wire logic [31:0] jump_at,
    input  wire logic [31:0] branch_at,
    input  wire logic        likely,
    input  wire logic        fetch_ready,
    input  wire logic        redirect_valid,
    input  wire logic [31:0] redirect_pc,
    output logic             fetch_valid,
    output logic [31:0]      fetch_pc,
    output logic [31:0]      fetch_instr,
    output logic             is_jump,
    output logic             is_branch,
    output logic             is_likely
);
    logic [31:0] pc;
    logic [31:0] cur;

    assign cur = redirect_valid ? redirect_pc : pc;
    assign fetch_valid = en;
    // An idle port shows junk so a stale word is never mistaken for data
    assign fetch_pc = en ? cur : ~cur;
    assign fetch_instr = en ? {cur[15:0], ~cur[15:0]}
                            : {~cur[15:0], cur[15:0]};
    assign is_jump = en && cur == jump_at;
    assign is_branch = en && cur == branch_at;
    assign is_likely = is_branch && likely;

    always @(posedge clock) begin
        if (!rst_n || load)
            pc <= #1 load_pc;
        else if (en && fetch_ready)
            pc <= #1 cur + 32'h4;
        else if (redirect_valid)
            pc <= #1 redirect_pc;
    end
endmodule : cpb_fetch_model
`default_nettype wire

// ==== dv/tb_cpu_pipeline_branch_delay.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_cpu_pipeline_branch_delay;
    logic        clock, rst_n, compact_mode, data_wait, en, load, likely;
    logic        fv, fj, fb, fl, fetch_ready, redirect_valid;
    logic        slot_dropped, phase_second, pipe_stall;
    logic [1:0]  taken, retire_valid;
    logic [6:0]  stage_valid0;
    logic [31:0] load_pc, jump_at, branch_at, target, fpc, finstr;
    logic [31:0] redirect_pc, retire_pc0, retire_instr0;
    logic [31:0] rq[$];
    logic        en2, fv2, fj2, fb2, fl2, fr2, rv2, sd2, ph2;
    logic [31:0] fpc2, fin2, rpc2;
    int          errors, checks, n;

    // Scalar build: expectations below hold for that variant, except those of t_twoph
    cpb_pipe #(.VARIANT(cpb_pkg::CPB_SCALAR)) u_dut (
        .clock(clock), .rst_n(rst_n), .clk_en(1'b1),
        .compact_mode(compact_mode), .fetch_valid({1'b0, fv}),
        .fetch_pc0(fpc), .fetch_pc1(fpc + 32'h4),
        .fetch_instr0(finstr), .fetch_instr1(~finstr),
        .fetch_is_jump({1'b0, fj}), .fetch_is_branch({1'b0, fb}),
        .fetch_is_likely({1'b0, fl}), .branch_taken(taken),
        .target_pc0(target), .target_pc1(target), .data_wait(data_wait),
        .fetch_ready(fetch_ready), .redirect_valid(redirect_valid),
        .redirect_pc(redirect_pc), .slot_dropped(slot_dropped),
        .phase_second(phase_second), .pipe_stall(pipe_stall),
        .stage_valid0(stage_valid0), .stage_valid1(),
        .retire_valid(retire_valid), .retire_pc0(retire_pc0),
        .retire_pc1(), .retire_instr0(retire_instr0), .retire_instr1());

    // Two-phase build on its own fetch port
    cpb_pipe #(.VARIANT(cpb_pkg::CPB_TWOPH)) u_dut_twoph (
        .clock(clock), .rst_n(rst_n), .clk_en(1'b1),
        .compact_mode(compact_mode), .fetch_valid({1'b0, fv2}),
        .fetch_pc0(fpc2), .fetch_pc1(fpc2 + 32'h4),
        .fetch_instr0(fin2), .fetch_instr1(~fin2),
        .fetch_is_jump({1'b0, fj2}), .fetch_is_branch({1'b0, fb2}),
        .fetch_is_likely({1'b0, fl2}), .branch_taken(taken),
        .target_pc0(target), .target_pc1(target), .data_wait(data_wait),
        .fetch_ready(fr2), .redirect_valid(rv2),
        .redirect_pc(rpc2), .slot_dropped(sd2),
        .phase_second(ph2), .pipe_stall(),
        .stage_valid0(), .stage_valid1(),
        .retire_valid(), .retire_pc0(),
        .retire_pc1(), .retire_instr0(), .retire_instr1());

    cpb_fetch_model u_icache (
        .clock(clock), .rst_n(rst_n), .en(en), .load(load),
        .load_pc(load_pc), .jump_at(jump_at), .branch_at(branch_at),
        .likely(likely), .fetch_ready(fetch_ready),
        .redirect_valid(redirect_valid), .redirect_pc(redirect_pc),
        .fetch_valid(fv), .fetch_pc(fpc), .fetch_instr(finstr),
        .is_jump(fj), .is_branch(fb), .is_likely(fl));

    cpb_fetch_model u_icache_twoph (
        .clock(clock), .rst_n(rst_n), .en(en2), .load(load),
        .load_pc(load_pc), .jump_at(jump_at), .branch_at(branch_at),
        .likely(likely), .fetch_ready(fr2),
        .redirect_valid(rv2), .redirect_pc(rpc2),
        .fetch_valid(fv2), .fetch_pc(fpc2), .fetch_instr(fin2),
        .is_jump(fj2), .is_branch(fb2), .is_likely(fl2));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic conclude();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : tick

    task automatic guard();
        @(negedge clock);
        n++;
        if (n > 300) begin
            errors++;
            $display("wait limit reached at %0t", $time);
            conclude();
        end
    endtask : guard

    // Retired addresses in order; a frozen writeback is logged once
    always @(negedge clock) begin
        if (retire_valid[0] === 1'b1 &&
            (rq.size() == 0 || rq[$] !== retire_pc0)) begin
            rq.push_back(retire_pc0);
            check(retire_instr0, {retire_pc0[15:0], ~retire_pc0[15:0]});
        end
    end

    // Mode only changes with an empty pipe, so no word straddles modes
    task automatic start(input logic cm, input logic [31:0] p);
        tick(1);
        en = 1'b0;
        n = 0;
        do guard(); while (stage_valid0 !== 7'h00);
        tick(1);
        compact_mode = cm;
        load = 1'b1;
        load_pc = p;
        taken = 2'b00;
        rq.delete();
        tick(1);
        load = 1'b0;
        en = 1'b1;
    endtask : start

    task automatic t_flow(input logic cm);
        int c;
        start(cm, 32'h0000_1000);
        n = 0;
        do guard(); while (stage_valid0[0] !== 1'b1);
        c = 0;
        do begin guard(); c++; end while (stage_valid0[6] !== 1'b1);
        check(32'(c), cm ? 32'h5 : 32'h4);
        tick(3);
        @(negedge clock);
        check(stage_valid0, cm ? 7'h5F : 7'h5D);
        check(rq[0], 32'h0000_1000);
        check(rq[1] - rq[0], 32'h4);
        check(rq[2] - rq[1], 32'h4);
        $display("flow test done, compact %0d", cm);
    endtask : t_flow

    task automatic t_jump(input logic cm, input logic br, input logic lk);
        int c;
        int i;
        logic [31:0] j;
        j = 32'h0000_2010;
        i = 0;
        start(cm, 32'h0000_2000);
        jump_at = br ? 32'hFFFF_FFFC : j;
        branch_at = br ? j : 32'hFFFF_FFFC;
        likely = lk;
        taken = {1'b0, br};
        target = 32'h0000_3000;
        n = 0;
        do guard(); while (redirect_valid !== 1'b1);
        check(redirect_pc, target);
        check(slot_dropped, cm | lk);
        c = 0;
        while (fetch_ready === 1'b0 && c < 8) begin
            c++;
            @(negedge clock);
        end
        check(32'(c), cm ? 32'h3 : 32'h2);
        n = 0;
        do guard(); while (rq[$] !== target);
        foreach (rq[k])
            if (rq[k] === j)
                i = k;
        check(rq[i - 1], j - 32'h4);
        check(rq[i + 1], (cm | lk) ? target : j + 32'h4);
        $display("jump test done, compact %0d branch %0d likely %0d",
                 cm, br, lk);
    endtask : t_jump

    task automatic t_twoph(input logic cm);
        int c;
        start(cm, 32'h0000_5000);
        en2 = 1'b1;
        jump_at = 32'h0000_5010;
        target = 32'h0000_6000;
        n = 0;
        do guard(); while (rv2 !== 1'b1);
        check(rpc2, target);
        check(sd2, cm);
        check(ph2, 1'b0);
        c = 0;
        while (fr2 === 1'b0 && c < 8) begin
            c++;
            @(negedge clock);
        end
        // Two clocks per delay cycle plus the redirect's own first phase
        check(32'(c), cm ? 32'h1 : 32'h3);
        tick(1);
        en2 = 1'b0;
        $display("two-phase test done, compact %0d", cm);
    endtask : t_twoph

    task automatic t_miss();
        logic [31:0] p;
        logic [6:0] v;
        start(1'b0, 32'h0000_4000);
        tick(8);
        data_wait = 1'b1;
        @(negedge clock);
        check(pipe_stall, 1'b1);
        p = retire_pc0;
        v = stage_valid0;
        tick(4);
        @(negedge clock);
        check(retire_pc0, p);
        check(stage_valid0, v);
        check(fetch_ready, 1'b0);
        tick(1);
        data_wait = 1'b0;
        tick(2);
        @(negedge clock);
        check(retire_pc0, p + 32'h8);
        $display("miss test done");
    endtask : t_miss

    initial begin
        errors = 0;
        checks = 0;
        rst_n = 1'b0;
        compact_mode = 1'b0;
        data_wait = 1'b0;
        en = 1'b0;
        en2 = 1'b0;
        load = 1'b0;
        likely = 1'b0;
        taken = 2'b00;
        load_pc = 32'h0000_1000;
        jump_at = 32'hFFFF_FFFC;
        branch_at = 32'hFFFF_FFFC;
        target = 32'h0000_0000;
        tick(12);
        rst_n = 1'b1;
        @(negedge clock);
        check(stage_valid0, 7'h00);
        check(redirect_valid, 1'b0);
        check(phase_second, 1'b0);
        $display("reset test done");
        t_flow(1'b0);
        t_flow(1'b1);
        t_jump(1'b0, 1'b0, 1'b0);
        t_jump(1'b1, 1'b0, 1'b0);
        t_jump(1'b0, 1'b1, 1'b0);
        t_jump(1'b0, 1'b1, 1'b1);
        t_jump(1'b1, 1'b1, 1'b0);
        t_twoph(1'b0);
        t_twoph(1'b1);
        t_miss();
        conclude();
    end
endmodule : tb_cpu_pipeline_branch_delay
`default_nettype wire
